// ==== hw/anpx_defines.svh ====
// Offsets, field positions and reset values for the partner and expansion registers.
// Assumes inclusion by every design file that decodes management accesses.
`ifndef ANPX_DEFINES_SVH
`define ANPX_DEFINES_SVH
`define ANPX_ADDR_PARTNER     5'h05
`define ANPX_ADDR_EXPANSION   5'h06
`define ANPX_PARTNER_RESET    16'h0000
`define ANPX_EXPANSION_RESET  16'h0004
`define ANPX_SEL_IEEE8023     5'h01
`define ANPX_SEL_IEEE8029     5'h02
`define ANPX_LP_NEXT_PAGE     15
`define ANPX_LP_ACK           14
`define ANPX_LP_REMOTE_FAULT  13
`define ANPX_LP_T4            9
`define ANPX_LP_RESV_MASK     16'h1e00
`define ANPX_LP_OVR_MASK      16'h000f
`define ANPX_EXP_PD_FAULT     4
`define ANPX_EXP_LP_NP_ABLE   3
`define ANPX_EXP_NP_ABLE      2
`define ANPX_EXP_PAGE_RX      1
`define ANPX_EXP_LP_AN_ABLE   0
`endif

// ==== hw/anpx_latch_bit.sv ====
// One latching-high status bit with clear on read.
// Assumes set and read strobes are single-cycle pulses on ref_clk.
`timescale 1ns/10ps
module anpx_latch_bit (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic set_evt,
  input  wire logic rd_clr,
  output logic      flag_r
);
  // A set arriving with the clearing read wins, so no event is lost.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flag_r <= 1'b0;
    end else if (set_evt) begin
      flag_r <= 1'b1;
    end else if (rd_clr) begin
      flag_r <= 1'b0;
    end
  end
endmodule

// ==== hw/anpx_pkg.sv ====
// Types shared by the partner and expansion register bank.
// Assumes the management frame decoder and negotiation engine share ref_clk.
package anpx_pkg;
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } anpx_page_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } anpx_mgmt_s;
endpackage

// ==== hw/anpx_regs.sv ====
// Partner ability and negotiation expansion registers with the sent selector field.
// Assumes the management decoder and negotiation engine run on ref_clk.
`timescale 1ns/10ps
`include "anpx_defines.svh"
module anpx_regs (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire anpx_pkg::anpx_mgmt_s mgmt,
  input  wire anpx_pkg::anpx_page_s page_in,
  input  wire logic              an_enable,
  input  wire logic [4:0]        adv_selector,
  input  wire logic              cmd_override,
  input  wire logic              flp_valid,
  input  wire logic              pd_fault_evt,
  output logic [4:0]             tx_selector_r,
  output logic                   sel_supported_r,
  output logic [15:0]            rd_data_r,
  output logic                   rd_valid_r
);
  logic [15:0] partner_r;
  logic        lp_np_able_r;
  logic        lp_an_able_r;
  logic        np_able_r;
  logic [1:0]  lh_flags;
  logic [1:0]  lh_set;
  logic        exp_rd;
  logic        part_wr_ok;
  logic [15:0] exp_view;
  logic [15:0] part_view;

  assign exp_rd     = mgmt.rd && (mgmt.addr == `ANPX_ADDR_EXPANSION);
  assign part_wr_ok = mgmt.wr && (mgmt.addr == `ANPX_ADDR_PARTNER) && cmd_override;
  assign lh_set     = {pd_fault_evt, page_in.valid};

  ////////////////////////////////////////////////////////////////////////////
  // Sent selector field.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_selector_r <= `ANPX_SEL_IEEE8023;
    end else if (an_enable) begin
      tx_selector_r <= adv_selector;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Partner ability register. Reserved and four-pair bits are never stored.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      partner_r <= `ANPX_PARTNER_RESET;
    end else if (page_in.valid) begin
      partner_r <= page_in.word & ~`ANPX_LP_RESV_MASK;
    end else if (part_wr_ok) begin
      partner_r <= (partner_r & ~`ANPX_LP_OVR_MASK) | (mgmt.wdata & `ANPX_LP_OVR_MASK);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_supported_r <= 1'b0;
    end else begin
      sel_supported_r <= (partner_r[4:0] == `ANPX_SEL_IEEE8023);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expansion status.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lp_np_able_r <= 1'b0;
    end else if (page_in.valid) begin
      lp_np_able_r <= page_in.word[`ANPX_LP_NEXT_PAGE];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lp_an_able_r <= 1'b0;
    end else if (flp_valid) begin
      lp_an_able_r <= 1'b1;
    end
  end

  // Kept as a flop so the reset value is visible even though it never changes.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      np_able_r <= 1'b1;
    end else begin
      np_able_r <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_lh
      anpx_latch_bit u_lh (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .set_evt (lh_set[gi]),
        .rd_clr  (exp_rd),
        .flag_r  (lh_flags[gi])
      );
    end
  endgenerate

  always_comb begin
    exp_view = 16'h0000;
    exp_view[`ANPX_EXP_PD_FAULT]    = lh_flags[1];
    exp_view[`ANPX_EXP_LP_NP_ABLE]  = lp_np_able_r;
    exp_view[`ANPX_EXP_NP_ABLE]     = np_able_r;
    exp_view[`ANPX_EXP_PAGE_RX]     = lh_flags[0];
    exp_view[`ANPX_EXP_LP_AN_ABLE]  = lp_an_able_r;
    part_view = partner_r & ~`ANPX_LP_RESV_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_r  <= 16'h0000;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= mgmt.rd;
      if (!mgmt.rd) begin
        rd_data_r <= rd_data_r;
      end else if (mgmt.addr == `ANPX_ADDR_PARTNER) begin
        rd_data_r <= part_view;
      end else if (mgmt.addr == `ANPX_ADDR_EXPANSION) begin
        rd_data_r <= exp_view;
      end else begin
        rd_data_r <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_sel_follow: assert property (@(posedge ref_clk) disable iff (!resetn)
    an_enable |=> tx_selector_r == $past(adv_selector))
    else $error("Sent selector does not follow advertisement.");

  a_lp_load: assert property (@(posedge ref_clk) disable iff (!resetn)
    page_in.valid |=> partner_r[15:13] == $past(page_in.word[15:13])
      && partner_r[12:9] == 4'h0
      && partner_r[8:0] == $past(page_in.word[8:0]))
    else $error("Partner register not loaded from page.");

  a_resv_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mgmt.rd && mgmt.addr == `ANPX_ADDR_PARTNER) |=> rd_valid_r && rd_data_r[12:9] == 4'h0)
    else $error("Reserved partner bits read nonzero.");

  a_lp_np_track: assert property (@(posedge ref_clk) disable iff (!resetn)
    page_in.valid |=> lp_np_able_r == $past(page_in.word[`ANPX_LP_NEXT_PAGE]))
    else $error("Partner next-page bits disagree.");

  a_np_able: assert property (@(posedge ref_clk) disable iff (!resetn)
    exp_rd |=> rd_data_r[`ANPX_EXP_NP_ABLE] && rd_data_r[15:5] == 11'h000)
    else $error("Expansion read shows wrong fixed bits.");

  a_page_latch: assert property (@(posedge ref_clk) disable iff (!resetn)
    page_in.valid |=> lh_flags[0])
    else $error("Page received not latched.");

  a_page_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    (exp_rd && !page_in.valid) |=> !lh_flags[0])
    else $error("Page received not cleared by read.");

  a_pd_latch: assert property (@(posedge ref_clk) disable iff (!resetn)
    (pd_fault_evt && exp_rd) |=> lh_flags[1])
    else $error("Fault lost on simultaneous read.");

  a_flp_set: assert property (@(posedge ref_clk) disable iff (!resetn)
    flp_valid |=> lp_an_able_r)
    else $error("Negotiation-able bit not set.");

  a_ovr_block: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mgmt.wr && !cmd_override && !page_in.valid) |=> $stable(partner_r))
    else $error("Write changed partner register without override.");

  a_ack_copy: assert property (@(posedge ref_clk) disable iff (!resetn)
    page_in.valid |=> partner_r[`ANPX_LP_ACK] == $past(page_in.word[`ANPX_LP_ACK]))
    else $error("Acknowledge bit not copied from page.");

  a_fault_copy: assert property (@(posedge ref_clk) disable iff (!resetn)
    page_in.valid |=> partner_r[`ANPX_LP_REMOTE_FAULT]
      == $past(page_in.word[`ANPX_LP_REMOTE_FAULT]))
    else $error("Remote fault bit not copied from page.");

  // The support flag lags the partner register by one cycle, hence two cycles here.
  a_sel_check: assert property (@(posedge ref_clk) disable iff (!resetn)
    page_in.valid |=> ##1
      sel_supported_r == ($past(page_in.word[4:0], 2) == `ANPX_SEL_IEEE8023))
    else $error("Selector support flag wrong.");

  a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mgmt.rd && mgmt.addr != `ANPX_ADDR_PARTNER && mgmt.addr != `ANPX_ADDR_EXPANSION)
      |=> rd_valid_r && rd_data_r == 16'h0000)
    else $error("Unmapped read returned nonzero.");

  a_sel_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    !an_enable |=> $stable(tx_selector_r))
    else $error("Sent selector changed with negotiation off.");

  a_page_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    (lh_flags[0] && !exp_rd) |=> lh_flags[0])
    else $error("Page received dropped without a read.");
endmodule

// ==== verif/anpx_link_partner.sv ====
// Behavioural remote link partner that offers one base page per request.
// Assumes the bench raises send for one cycle, changed at the falling edge.
`timescale 1ns/10ps
module anpx_link_partner (
  input  wire logic            send,
  input  wire logic [15:0]     word_in,
  output anpx_pkg::anpx_page_s page_out
);
  // Between pages the word shows its inverse, so stale data can never pass for a page.
  assign page_out = {send, send ? word_in : ~word_in};
endmodule

// ==== verif/autoneg_partner_expansion_regs_bench.sv ====
// Self-checking bench for the partner ability and expansion registers.
// Assumes the design reads back one cycle after the read strobe is taken.
`timescale 1ns/10ps
module autoneg_partner_expansion_regs_bench;
  logic                 ref_clk      = 1'b0;
  logic                 resetn       = 1'b0;
  anpx_pkg::anpx_mgmt_s mgmt         = '0;
  anpx_pkg::anpx_page_s page_w;
  logic                 an_enable    = 1'b1;
  logic                 cmd_override = 1'b0;
  logic                 flp_valid    = 1'b0;
  logic                 pd_fault_evt = 1'b0;
  logic                 send         = 1'b0;
  logic [4:0]           adv_selector = 5'h01;
  logic [15:0]          word         = 16'h0000;
  logic [15:0]          d;
  logic [4:0]           tx_sel;
  logic                 sel_ok;
  logic                 rd_v;
  logic [15:0]          rd_d;
  int                   errors       = 0;
  int                   checks_done  = 0;
  // Each row: received word, partner register, expansion register.
  logic [47:0]          rows [4]     = '{48'hffff_e1ff_000f, 48'h0021_0021_0007,
                                        48'h41e2_41e2_0007, 48'h3e01_2001_0007};
  ////////////////////////////////////////////////////////////////////////////////
  always #2 ref_clk = ~ref_clk;
  anpx_link_partner u_lp (.send(send), .word_in(word), .page_out(page_w));
  anpx_regs dut (.ref_clk(ref_clk), .resetn(resetn), .mgmt(mgmt), .page_in(page_w),
    .an_enable(an_enable), .adv_selector(adv_selector), .cmd_override(cmd_override),
    .flp_valid(flp_valid), .pd_fault_evt(pd_fault_evt), .tx_selector_r(tx_sel),
    .sel_supported_r(sel_ok), .rd_data_r(rd_d), .rd_valid_r(rd_v));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [4:0] a);
    @(negedge ref_clk);
    mgmt = '{1'b1, 1'b0, a, 16'h0000};
    @(negedge ref_clk);
    mgmt.rd = 1'b0;
    chk("read strobe", {15'h0000, rd_v}, 16'h0001);
    d = rd_d;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge ref_clk);
    mgmt = '{1'b0, 1'b1, a, v};
    @(negedge ref_clk);
    mgmt.wr = 1'b0;
  endtask
  task automatic pg(input logic [15:0] w);
    @(negedge ref_clk);
    send = 1'b1;
    word = w;
    @(negedge ref_clk);
    send = 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // The whole sequence needs well under two thousand cycles.
  initial begin
    #20000;
    errors++;
    final_report();
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    rd(5'h05);
    chk("partner reset", d, 16'h0000);
    rd(5'h06);
    chk("expansion reset", d, 16'h0004);
    chk("sent selector", {11'h000, tx_sel}, 16'h0001);
    flp_valid = 1'b1;
    @(negedge ref_clk);
    flp_valid = 1'b0;
    rd(5'h06);
    chk("burst seen", d, 16'h0005);
    for (int i = 0; i < 4; i++) begin
      pg(rows[i][47:32]);
      rd(5'h05);
      chk("partner word", d, rows[i][31:16]);
      chk("selector ok", {15'h0000, sel_ok}, {15'h0000, rows[i][36:32] == 5'h01});
      rd(5'h06);
      chk("expansion", d, rows[i][15:0]);
      rd(5'h06);
      chk("expansion reread", d, rows[i][15:0] & 16'hfffd);
    end
    adv_selector = 5'h02;
    repeat (2) @(negedge ref_clk);
    chk("sent selector follows", {11'h000, tx_sel}, 16'h0002);
    an_enable = 1'b0;
    adv_selector = 5'h01;
    repeat (2) @(negedge ref_clk);
    chk("sent selector held", {11'h000, tx_sel}, 16'h0002);
    adv_selector = 5'h02;
    an_enable = 1'b1;
    wr(5'h05, 16'h000a);
    rd(5'h05);
    chk("locked write", d, 16'h2001);
    cmd_override = 1'b1;
    wr(5'h05, 16'h000a);
    rd(5'h05);
    chk("override write", d, 16'h200a);
    cmd_override = 1'b0;
    wr(5'h06, 16'h001a);
    rd(5'h06);
    chk("expansion write", d, 16'h0005);
    rd(5'h07);
    chk("unmapped", d, 16'h0000);
    pd_fault_evt = 1'b1;
    @(negedge ref_clk);
    pd_fault_evt = 1'b0;
    rd(5'h06);
    chk("fault latched", d, 16'h0015);
    rd(5'h06);
    chk("fault cleared", d, 16'h0005);
    @(negedge ref_clk);
    send = 1'b1;
    word = 16'h8001;
    pd_fault_evt = 1'b1;
    mgmt = '{1'b1, 1'b0, 5'h06, 16'h0000};
    @(negedge ref_clk);
    send = 1'b0;
    pd_fault_evt = 1'b0;
    mgmt.rd = 1'b0;
    chk("read beside set", rd_d, 16'h0005);
    rd(5'h06);
    chk("set beats clear", d, 16'h001f);
    resetn = 1'b0;
    @(negedge ref_clk);
    chk("selector on reset", {11'h000, tx_sel}, 16'h0001);
    chk("read idle on reset", {15'h0000, rd_v}, 16'h0000);
    resetn = 1'b1;
    rd(5'h06);
    chk("expansion re-reset", d, 16'h0004);
    rd(5'h05);
    chk("partner re-reset", d, 16'h0000);
    final_report();
  end
endmodule
